// ==== design/bgs_pkg.sv ====
// Shared constants and types of the battery gauge measurement sequencer.
// Assumes a byte-wide register port fed by an external serial slave and a
// slow time-base clock that paces the converter slots.
package bgs_pkg;

	//----------------------------------------------------------------
	// Register addresses
	//----------------------------------------------------------------
	localparam logic [7:0] BGS_ADDR_MODE = 8'h00;
	localparam logic [7:0] BGS_ADDR_CTRL = 8'h01;
	localparam logic [7:0] BGS_ADDR_CHARGE_LO = 8'h02;
	localparam logic [7:0] BGS_ADDR_CHARGE_HI = 8'h03;
	localparam logic [7:0] BGS_ADDR_COUNT_LO = 8'h04;
	localparam logic [7:0] BGS_ADDR_COUNT_HI = 8'h05;
	localparam logic [7:0] BGS_ADDR_CURRENT_LO = 8'h06;
	localparam logic [7:0] BGS_ADDR_CURRENT_HI = 8'h07;
	localparam logic [7:0] BGS_ADDR_VOLTAGE_LO = 8'h08;
	localparam logic [7:0] BGS_ADDR_VOLTAGE_HI = 8'h09;
	localparam logic [7:0] BGS_ADDR_BASE_LO = 8'h0A;
	localparam logic [7:0] BGS_ADDR_BASE_HI = 8'h0B;
	localparam logic [7:0] BGS_ADDR_ALM_CHG_LO = 8'h0C;
	localparam logic [7:0] BGS_ADDR_ALM_CHG_HI = 8'h0D;
	localparam logic [7:0] BGS_ADDR_LOW_VOLTAGE_FLAG = 8'h0E;
	localparam logic [7:0] BGS_ADDR_CUR_THR = 8'h0F;
	localparam logic [7:0] BGS_ADDR_RELAX = 8'h10;

	//----------------------------------------------------------------
	// Field positions and reset values
	//----------------------------------------------------------------
	localparam int BGS_MODE_LOW_POWER = 2;
	localparam int BGS_MODE_ALARM_EN = 3;
	localparam int BGS_MODE_RUN = 4;
	localparam int BGS_CTRL_PIN = 0;
	localparam int BGS_CTRL_GRESET = 1;
	localparam int BGS_CTRL_LOW_CHG = 5;
	localparam int BGS_CTRL_LOW_VOLT = 6;
	localparam logic BGS_PIN_CTRL_RST = 1'b1;
	localparam logic [7:0] BGS_RELAX_MAX = 8'hFF;
	localparam int BGS_RELAX_DIV = 2;
	localparam int BGS_THR_SHIFT = 5;
	localparam int BGS_VOLT_ALM_SHIFT = 4;

	//----------------------------------------------------------------
	// Widths and timing
	//----------------------------------------------------------------
	localparam int BGS_ACC_W = 28;
	localparam int BGS_CUR_W = 14;
	localparam int BGS_VOLT_W = 12;
	localparam int BGS_TB_HZ = 32768;
	localparam int BGS_VOLT_SLOT_MS = 250;
	localparam int BGS_CUR_SLOT_MS = 500;
	localparam int BGS_FRAME_MS = 4000;
	localparam int BGS_VOLT_CYC = BGS_VOLT_SLOT_MS * BGS_TB_HZ / 1000;
	localparam int BGS_CUR_CYC = BGS_CUR_SLOT_MS * BGS_TB_HZ / 1000;
	localparam int BGS_SLOTS =
		(BGS_FRAME_MS - 2 * BGS_VOLT_SLOT_MS) / BGS_CUR_SLOT_MS;

	//----------------------------------------------------------------
	// Types
	//----------------------------------------------------------------
	typedef enum logic [4:0] {
		BGS_ST_IDLE = 5'h01,
		BGS_ST_VOLT = 5'h02,
		BGS_ST_CUR = 5'h04,
		BGS_ST_SKIP = 5'h08,
		BGS_ST_PAD = 5'h10
	} bgs_state_t;

	typedef enum logic [1:0] {
		BGS_EV_VOLT = 2'h0,
		BGS_EV_CUR = 2'h1,
		BGS_EV_REUSE = 2'h2
	} bgs_ev_kind_t;

	typedef struct packed {
		bgs_ev_kind_t kind;
		logic [BGS_CUR_W-1:0] cur;
		logic [BGS_VOLT_W-1:0] volt;
	} bgs_event_t;

endpackage : bgs_pkg

// ==== design/bgs_sequencer.sv ====
// Battery gauge measurement sequencer, accumulator, relaxation counter
// and latched alarm output with its byte-wide register file.
// Assumes converter results arrive on the time-base clock and a serial
// slave drives the register port on the system clock.
//
// What this block does
// - Low power measures current in the four odd slots of seven
// - Normal: current always, voltage every 4 s
// - Reset returns every register to default
// - Run cleared freezes measurement, then resumes
// - Voltage slot lasts 8192 time-base cycles
// - Voltage code unsigned, 2.44 mV step
// - Current slot 500 ms, 14-bit signed code
// - Each current result accumulates, counter increments
// - Charge is accumulator top plus base
// - Pin control 0 forces pin low; reads pin
// - Enabled alarm pulls pin on low condition
// - Trigger sets matching low flag
// - Pin stays low until both flags cleared
// - Condition must go false before re-alarming
// - Reset clears enable, thresholds, base, relax
// - Light load: relax counts per 8 s, saturates
// - Charging or heavy load clears relax counter
// - Eight-bit current threshold, 0.4 percent steps
// - First conversion after run is voltage
// - Accumulator updated every 500 ms, last current
// - Clearing run aborts conversion in progress
// - Mode bits: 2 low power, 3 alarm, 4 run
`timescale 1ns/1ns

module bgs_sequencer #(
	parameter int VOLT_CYCLES = bgs_pkg::BGS_VOLT_CYC,
	parameter int CUR_CYCLES = bgs_pkg::BGS_CUR_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic alarm_pin_in,
	output logic alarm_pin_out,
	output logic alarm_pin_oe,
	input wire logic tb_clk,
	output logic adc_voltage_go,
	output logic adc_current_go,
	input wire logic [bgs_pkg::BGS_CUR_W-1:0] adc_current_code,
	input wire logic [bgs_pkg::BGS_VOLT_W-1:0] adc_voltage_code
);

	localparam logic [14:0] VOLT_LAST = 15'(VOLT_CYCLES - 1);
	localparam logic [14:0] CUR_LAST = 15'(CUR_CYCLES - 1);
	localparam logic [2:0] LAST_SLOT = 3'(bgs_pkg::BGS_SLOTS);

	//----------------------------------------------------------------
	// Register file state (system clock)
	//----------------------------------------------------------------
	logic low_power_select;
	logic alarm_enable;
	logic gauge_run;
	logic alarm_pin_control;
	logic low_charge_flag;
	logic low_voltage_flag;
	logic [15:0] soc_base;
	logic [15:0] alarm_charge_level;
	logic [7:0] alarm_voltage_level;
	logic [7:0] current_threshold;
	logic [7:0] relaxation_count;
	logic [bgs_pkg::BGS_ACC_W-1:0] accum;
	logic [15:0] conv_count;
	logic [15:0] charge;
	logic [bgs_pkg::BGS_CUR_W-1:0] current_code;
	logic [bgs_pkg::BGS_VOLT_W-1:0] voltage_code;
	logic volt_parity;
	logic [7:0] read_shadow;
	logic wr_ctrl;
	logic greset;

	assign wr_ctrl = reg_wr && reg_addr == bgs_pkg::BGS_ADDR_CTRL;
	assign greset = wr_ctrl && reg_wdata[bgs_pkg::BGS_CTRL_GRESET];

	//----------------------------------------------------------------
	// Time-base domain: control sync and slot sequencer
	//----------------------------------------------------------------
	logic rst_s1, tb_rst;
	logic run_s1, run_s2, run_s3, run_tb;
	logic lp_s1, lp_s2, lp_s3, lp_tb;
	bgs_pkg::bgs_state_t st;
	logic [14:0] cyc;
	logic [2:0] slot;
	logic ev_tgl;
	bgs_pkg::bgs_event_t ev_data;
	logic volt_end, slot_end;

	// Reset enters the slow domain through two stages
	always_ff @(posedge tb_clk) begin
		rst_s1 <= sys_rst;
		tb_rst <= rst_s1;
	end

	// Run and low-power levels: a change counts when stages 2 and 3 agree
	always_ff @(posedge tb_clk) begin
		run_s1 <= gauge_run;
		run_s2 <= run_s1;
		run_s3 <= run_s2;
		lp_s1 <= low_power_select;
		lp_s2 <= lp_s1;
		lp_s3 <= lp_s2;
		if (tb_rst) begin
			run_tb <= 1'b0;
			lp_tb <= 1'b0;
		end else begin
			if (run_s2 == run_s3)
				run_tb <= run_s3;
			if (lp_s2 == lp_s3)
				lp_tb <= lp_s3;
		end
	end

	// Odd slots always convert; even ones idle only in low power
	function automatic bgs_pkg::bgs_state_t slot_kind(input logic [2:0] idx,
		input logic lp);
		slot_kind = (lp && !idx[0]) ? bgs_pkg::BGS_ST_SKIP :
			bgs_pkg::BGS_ST_CUR;
	endfunction : slot_kind

	assign volt_end = (st == bgs_pkg::BGS_ST_VOLT) && cyc == VOLT_LAST;
	assign slot_end = (st == bgs_pkg::BGS_ST_CUR ||
		st == bgs_pkg::BGS_ST_SKIP) && cyc == CUR_LAST;

	// Frame: one voltage slot, seven 500 ms slots, one 250 ms pad = 4 s
	always_ff @(posedge tb_clk) begin
		if (tb_rst || !run_tb) begin
			st <= bgs_pkg::BGS_ST_IDLE;
			cyc <= 15'h0000;
			slot <= 3'h0;
		end else begin
			unique case (st)
			bgs_pkg::BGS_ST_IDLE: begin
				st <= bgs_pkg::BGS_ST_VOLT;
				cyc <= 15'h0000;
			end
			bgs_pkg::BGS_ST_VOLT: begin
				cyc <= volt_end ? 15'h0000 : cyc + 15'h0001;
				if (volt_end) begin
					st <= slot_kind(3'h1, lp_tb);
					slot <= 3'h1;
				end
			end
			bgs_pkg::BGS_ST_CUR, bgs_pkg::BGS_ST_SKIP: begin
				cyc <= slot_end ? 15'h0000 : cyc + 15'h0001;
				if (slot_end) begin
					if (slot == LAST_SLOT)
						st <= bgs_pkg::BGS_ST_PAD;
					else
						st <= slot_kind(slot + 3'h1, lp_tb);
					slot <= slot + 3'h1;
				end
			end
			bgs_pkg::BGS_ST_PAD: begin
				cyc <= (cyc == VOLT_LAST) ? 15'h0000 : cyc + 15'h0001;
				if (cyc == VOLT_LAST)
					st <= bgs_pkg::BGS_ST_VOLT;
			end
			default: st <= bgs_pkg::BGS_ST_IDLE;
			endcase
		end
	end

	// Converter steering; an aborted slot just drops its go level
	assign adc_voltage_go = st == bgs_pkg::BGS_ST_VOLT;
	assign adc_current_go = st == bgs_pkg::BGS_ST_CUR;

	// Slot results leave as a toggle; data holds for a whole slot
	always_ff @(posedge tb_clk) begin
		if (tb_rst) begin
			ev_tgl <= 1'b0;
			ev_data <= '0;
		end else if (run_tb && (volt_end || slot_end)) begin
			ev_tgl <= ~ev_tgl;
			ev_data.cur <= adc_current_code;
			ev_data.volt <= adc_voltage_code;
			if (volt_end)
				ev_data.kind <= bgs_pkg::BGS_EV_VOLT;
			else if (st == bgs_pkg::BGS_ST_CUR)
				ev_data.kind <= bgs_pkg::BGS_EV_CUR;
			else
				ev_data.kind <= bgs_pkg::BGS_EV_REUSE;
		end
	end

	//----------------------------------------------------------------
	// Event crossing into the system clock
	//----------------------------------------------------------------
	logic ev_s1, ev_s2, ev_s3, ev_seen, ev_fire;
	logic ev_volt, ev_cur, ev_reuse;

	always_ff @(posedge clk) begin
		ev_s1 <= ev_tgl;
		ev_s2 <= ev_s1;
		ev_s3 <= ev_s2;
		if (sys_rst)
			ev_seen <= 1'b0;
		else if (ev_s2 == ev_s3)
			ev_seen <= ev_s3;
	end

	// Results landing while stopped are dropped so registers stay frozen
	assign ev_fire = (ev_s2 == ev_s3) && (ev_s3 != ev_seen) && gauge_run;
	assign ev_volt = ev_fire && ev_data.kind == bgs_pkg::BGS_EV_VOLT;
	assign ev_cur = ev_fire && ev_data.kind == bgs_pkg::BGS_EV_CUR;
	assign ev_reuse = ev_fire && ev_data.kind == bgs_pkg::BGS_EV_REUSE;

	//----------------------------------------------------------------
	// Measurement registers
	//----------------------------------------------------------------
	logic signed [bgs_pkg::BGS_CUR_W-1:0] cur_s, neg_thr;
	logic light_load, relax_clear;

	// Latest results; the reuse slot keeps the previous current
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			current_code <= '0;
			voltage_code <= '0;
		end else begin
			if (ev_cur)
				current_code <= ev_data.cur;
			if (ev_volt)
				voltage_code <= ev_data.volt;
		end
	end

	// Coulomb accumulator and conversion count
	always_ff @(posedge clk) begin
		if (sys_rst || greset) begin
			accum <= '0;
			conv_count <= 16'h0000;
		end else if (ev_cur) begin
			accum <= accum + {{(bgs_pkg::BGS_ACC_W - bgs_pkg::BGS_CUR_W)
				{ev_data.cur[bgs_pkg::BGS_CUR_W-1]}}, ev_data.cur};
			conv_count <= conv_count + 16'h0001;
		end else if (ev_reuse) begin
			accum <= accum + {{(bgs_pkg::BGS_ACC_W - bgs_pkg::BGS_CUR_W)
				{current_code[bgs_pkg::BGS_CUR_W-1]}}, current_code};
		end
	end

	// Charge register follows accumulator top plus base
	always_ff @(posedge clk) begin
		if (sys_rst)
			charge <= 16'h0000;
		else
			charge <= accum[bgs_pkg::BGS_ACC_W-1 -: 16] + soc_base;
	end

	// Threshold is 1/256 of full scale per step, on the discharge side
	assign cur_s = $signed(current_code);
	assign neg_thr = -$signed({1'b0,
		current_threshold, {bgs_pkg::BGS_THR_SHIFT{1'b0}}});
	assign light_load = cur_s < 0 && cur_s > neg_thr;
	assign relax_clear = cur_s > 0 || cur_s < neg_thr;

	// Relaxation counter ticks on every second voltage result
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			relaxation_count <= 8'h00;
			volt_parity <= 1'b0;
		end else begin
			if (ev_volt)
				volt_parity <= ~volt_parity;
			if (relax_clear)
				relaxation_count <= 8'h00;
			else if (ev_volt && volt_parity && light_load &&
				relaxation_count != bgs_pkg::BGS_RELAX_MAX)
				relaxation_count <= relaxation_count + 8'h01;
		end
	end

	//----------------------------------------------------------------
	// Alarm logic
	//----------------------------------------------------------------
	logic low_chg_cond, low_volt_cond, arm_chg, arm_volt;
	logic trig_chg, trig_volt, alarm_low;
	logic pin_s1, pin_s2, pin_s3, pin_level;

	assign low_chg_cond = $signed(charge) < $signed(alarm_charge_level);
	assign low_volt_cond = voltage_code < {alarm_voltage_level,
		{bgs_pkg::BGS_VOLT_ALM_SHIFT{1'b0}}};
	assign trig_chg = alarm_enable && low_chg_cond && arm_chg;
	assign trig_volt = alarm_enable && low_volt_cond && arm_volt;

	// Each alarm re-arms only once its condition has gone false
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			arm_chg <= 1'b0;
			arm_volt <= 1'b0;
		end else begin
			arm_chg <= !low_chg_cond || (arm_chg && !trig_chg);
			arm_volt <= !low_volt_cond || (arm_volt && !trig_volt);
		end
	end

	// Flags: a trigger beats a clear written in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			low_charge_flag <= 1'b0;
			low_voltage_flag <= 1'b0;
		end else begin
			if (trig_chg)
				low_charge_flag <= 1'b1;
			else if (wr_ctrl && !reg_wdata[bgs_pkg::BGS_CTRL_LOW_CHG])
				low_charge_flag <= 1'b0;
			if (trig_volt)
				low_voltage_flag <= 1'b1;
			else if (wr_ctrl && !reg_wdata[bgs_pkg::BGS_CTRL_LOW_VOLT])
				low_voltage_flag <= 1'b0;
		end
	end

	// Open-drain drive, registered so the pin never glitches
	always_ff @(posedge clk) begin
		if (sys_rst)
			alarm_low <= !bgs_pkg::BGS_PIN_CTRL_RST;
		else
			alarm_low <= !alarm_pin_control ||
				(alarm_enable && (low_charge_flag || low_voltage_flag));
	end

	assign alarm_pin_out = 1'b0;
	assign alarm_pin_oe = alarm_low;

	// Pin readback; the wire may be held low by another driver
	always_ff @(posedge clk) begin
		pin_s1 <= alarm_pin_in;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
		if (sys_rst)
			pin_level <= 1'b1;
		else if (pin_s2 == pin_s3)
			pin_level <= pin_s3;
	end

	//----------------------------------------------------------------
	// Register writes
	//----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			low_power_select <= 1'b0;
			alarm_enable <= 1'b0;
			gauge_run <= 1'b0;
			alarm_pin_control <= bgs_pkg::BGS_PIN_CTRL_RST;
			soc_base <= 16'h0000;
			alarm_charge_level <= 16'h0000;
			alarm_voltage_level <= 8'h00;
			current_threshold <= 8'h00;
		end else if (reg_wr) begin
			unique case (reg_addr)
			bgs_pkg::BGS_ADDR_MODE: begin
				low_power_select <= reg_wdata[bgs_pkg::BGS_MODE_LOW_POWER];
				alarm_enable <= reg_wdata[bgs_pkg::BGS_MODE_ALARM_EN];
				gauge_run <= reg_wdata[bgs_pkg::BGS_MODE_RUN];
			end
			bgs_pkg::BGS_ADDR_CTRL:
				alarm_pin_control <= reg_wdata[bgs_pkg::BGS_CTRL_PIN];
			bgs_pkg::BGS_ADDR_BASE_LO: soc_base[7:0] <= reg_wdata;
			bgs_pkg::BGS_ADDR_BASE_HI: soc_base[15:8] <= reg_wdata;
			bgs_pkg::BGS_ADDR_ALM_CHG_LO: alarm_charge_level[7:0] <= reg_wdata;
			bgs_pkg::BGS_ADDR_ALM_CHG_HI:
				alarm_charge_level[15:8] <= reg_wdata;
			bgs_pkg::BGS_ADDR_LOW_VOLTAGE_FLAG: alarm_voltage_level <= reg_wdata;
			bgs_pkg::BGS_ADDR_CUR_THR: current_threshold <= reg_wdata;
			default: ;
			endcase
		end
	end

	//----------------------------------------------------------------
	// Register reads
	//----------------------------------------------------------------
	logic [15:0] cur_ext, volt_ext;
	assign cur_ext = 16'($signed(current_code));
	assign volt_ext = {4'h0, voltage_code};

	// Reading a charge, count, current or voltage low byte parks its high byte, so a pair reads coherently
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			read_shadow <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
			bgs_pkg::BGS_ADDR_MODE: reg_rdata <= {3'h0, gauge_run,
				alarm_enable, low_power_select, 2'h0};
			bgs_pkg::BGS_ADDR_CTRL: reg_rdata <= {1'b0, low_voltage_flag,
				low_charge_flag, 4'h0, pin_level};
			bgs_pkg::BGS_ADDR_CHARGE_LO: begin
				reg_rdata <= charge[7:0];
				read_shadow <= charge[15:8];
			end
			bgs_pkg::BGS_ADDR_COUNT_LO: begin
				reg_rdata <= conv_count[7:0];
				read_shadow <= conv_count[15:8];
			end
			bgs_pkg::BGS_ADDR_CURRENT_LO: begin
				reg_rdata <= cur_ext[7:0];
				read_shadow <= cur_ext[15:8];
			end
			bgs_pkg::BGS_ADDR_VOLTAGE_LO: begin
				reg_rdata <= volt_ext[7:0];
				read_shadow <= volt_ext[15:8];
			end
			bgs_pkg::BGS_ADDR_CHARGE_HI, bgs_pkg::BGS_ADDR_COUNT_HI,
			bgs_pkg::BGS_ADDR_CURRENT_HI, bgs_pkg::BGS_ADDR_VOLTAGE_HI:
				reg_rdata <= read_shadow;
			bgs_pkg::BGS_ADDR_BASE_LO: reg_rdata <= soc_base[7:0];
			bgs_pkg::BGS_ADDR_BASE_HI: reg_rdata <= soc_base[15:8];
			bgs_pkg::BGS_ADDR_ALM_CHG_LO: reg_rdata <= alarm_charge_level[7:0];
			bgs_pkg::BGS_ADDR_ALM_CHG_HI: reg_rdata <= alarm_charge_level[15:8];
			bgs_pkg::BGS_ADDR_LOW_VOLTAGE_FLAG: reg_rdata <= alarm_voltage_level;
			bgs_pkg::BGS_ADDR_CUR_THR: reg_rdata <= current_threshold;
			bgs_pkg::BGS_ADDR_RELAX: reg_rdata <= relaxation_count;
			default: reg_rdata <= 8'h00;
			endcase
		end
	end

	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------
	chk_first_volt: assert property (@(posedge tb_clk)
		disable iff (tb_rst) (st == bgs_pkg::BGS_ST_IDLE && run_tb)
		|=> st == bgs_pkg::BGS_ST_VOLT)
		else $error("run start did not open a voltage slot");
	chk_abort_idle: assert property (@(posedge tb_clk)
		disable iff (tb_rst)
		!run_tb |=> st == bgs_pkg::BGS_ST_IDLE && !adc_current_go)
		else $error("conversion not aborted when run cleared");
	chk_volt_slot_end: assert property (@(posedge tb_clk)
		disable iff (tb_rst)
		(volt_end && run_tb) |=> $changed(ev_tgl) &&
		st != bgs_pkg::BGS_ST_VOLT)
		else $error("voltage slot did not end on its last cycle");
	// Checked at the slot boundary, so a mid-frame mode change is legal
	chk_low_power_skip: assert property (@(posedge tb_clk)
		disable iff (tb_rst)
		(slot_end && run_tb && lp_tb && slot[0] && slot != LAST_SLOT)
		|=> st == bgs_pkg::BGS_ST_SKIP)
		else $error("current slot taken where low power idles");
	chk_count_step: assert property (@(posedge clk) disable iff (sys_rst)
		(ev_cur && !greset) |=> conv_count == $past(conv_count) + 16'h0001)
		else $error("conversion count did not step");
	chk_run_freeze: assert property (@(posedge clk) disable iff (sys_rst)
		(!gauge_run && !greset) |=> $stable(accum) && $stable(conv_count))
		else $error("accumulator moved while stopped");
	chk_charge_sum: assert property (@(posedge clk) disable iff (sys_rst)
		##1 charge == $past(accum[bgs_pkg::BGS_ACC_W-1 -: 16]) + $past(soc_base))
		else $error("charge is not accumulator top plus base");
	chk_pin_force: assert property (@(posedge clk) disable iff (sys_rst)
		!alarm_pin_control |=> alarm_pin_oe)
		else $error("pin not forced low");
	chk_flag_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(low_voltage_flag && !wr_ctrl) |=> low_voltage_flag ##1
		(alarm_pin_oe || !$past(alarm_enable)))
		else $error("low voltage flag dropped without a clear");
	chk_relax_sat: assert property (@(posedge clk) disable iff (sys_rst)
		(relaxation_count == bgs_pkg::BGS_RELAX_MAX && !relax_clear)
		|=> relaxation_count == bgs_pkg::BGS_RELAX_MAX)
		else $error("relaxation counter left saturation");
	chk_relax_clear: assert property (@(posedge clk) disable iff (sys_rst)
		relax_clear |=> relaxation_count == 8'h00)
		else $error("relaxation counter not cleared");
	chk_no_rearm: assert property (@(posedge clk) disable iff (sys_rst)
		(trig_chg ##1 low_chg_cond) |-> !trig_chg)
		else $error("alarm raised again without condition going false");

	cov_volt_event: cover property (@(posedge clk) disable iff (sys_rst)
		ev_volt);
	cov_reuse_event: cover property (@(posedge clk) disable iff (sys_rst)
		ev_reuse);
	cov_alarm_fire: cover property (@(posedge clk) disable iff (sys_rst)
		trig_chg ##1 alarm_pin_oe);
	cov_relax_tick: cover property (@(posedge clk) disable iff (sys_rst)
		relaxation_count == 8'h01);

endmodule : bgs_sequencer

// ==== tb/battery_gauge_sequencer_test.sv ====
// Self-checking bench for the gauge sequencer: registers, frames, alarm.
// Assumes short slot parameters and the converter model beside the design.
`timescale 1ns/1ns

module battery_gauge_sequencer_test;
	logic clk = 1'b0;
	logic tb_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic pin, pin_out, pin_oe, vgo, cgo;
	logic [13:0] cur_val = 14'h1FFF;
	logic [13:0] cur_code;
	logic [11:0] volt_val = 12'h800;
	logic [11:0] volt_code;
	logic [15:0] v;
	int fail_count = 0;
	int total_checks = 0;

	// -----------------------------------------------------------------
	// Clocks and instances
	// -----------------------------------------------------------------
	always #10 clk = ~clk;
	// 32 ns time base; its rising edges never meet those of clk
	always #16 tb_clk = ~tb_clk;

	bgs_sequencer #(.VOLT_CYCLES(16), .CUR_CYCLES(32)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .alarm_pin_in(pin),
		.alarm_pin_out(pin_out), .alarm_pin_oe(pin_oe), .tb_clk(tb_clk),
		.adc_voltage_go(vgo), .adc_current_go(cgo),
		.adc_current_code(cur_code), .adc_voltage_code(volt_code));

	bgs_far_model far_u (.tb_clk(tb_clk), .volt_go(vgo), .cur_go(cgo),
		.cur_val(cur_val), .volt_val(volt_val), .pin_oe(pin_oe),
		.pin_out(pin_out), .cur_code(cur_code), .volt_code(volt_code),
		.pin(pin));

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask : wr

	// Read data is registered, so it is taken one edge after the strobe
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		d = {8'h00, reg_rdata};
	endtask : rd

	// Low byte first: it parks the high byte for a coherent pair
	task rd16(input logic [7:0] a, output logic [15:0] d);
		logic [15:0] lo, hi;
		rd(a, lo);
		rd(a + 8'h01, hi);
		d = {hi[7:0], lo[7:0]};
	endtask : rd16

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task t_reset;
		logic [7:0] zl [6] = '{8'h00, 8'h0A, 8'h0C, 8'h0E, 8'h0F, 8'h10};
		foreach (zl[i]) begin
			rd(zl[i], v);
			chk(v, 16'h0000);
		end
		rd(8'h01, v);
		chk(v, 16'h0001);
		rd(8'h30, v);
		chk(v, 16'h0000);
		$display("t_reset done");
	endtask : t_reset

	task t_regs;
		wr(8'h0F, 8'hA5);
		rd(8'h0F, v);
		chk(v, 16'h00A5);
		wr(8'h10, 8'h55);
		rd(8'h10, v);
		chk(v, 16'h0000);
		wr(8'h0A, 8'h34);
		wr(8'h0B, 8'h12);
		wr(8'h01, 8'h03);
		$display("t_regs done");
	endtask : t_regs

	// One 256-cycle frame from the first slot, then run is cleared
	task t_frame(input logic [7:0] mode, input int exp_c,
		input logic [15:0] cnt, input logic [15:0] chg);
		int nv, nc, i;
		nv = 0;
		nc = 0;
		i = 0;
		wr(8'h00, mode);
		while (vgo !== 1'b1 && cgo !== 1'b1 && i < 400) begin
			@(negedge tb_clk);
			i++;
		end
		if (i == 400) begin
			fail_count++;
			$display("ERROR %0t no slot started after run", $time);
			tally_and_finish;
		end
		chk({15'h0000, vgo}, 16'h0001);
		repeat (256) begin
			nv += int'(vgo);
			nc += int'(cgo);
			@(negedge tb_clk);
		end
		chk(nv[15:0], 16'h0010);
		chk(nc[15:0], exp_c[15:0]);
		wr(8'h00, 8'h00);
		repeat (20) @(posedge clk);
		rd16(8'h04, v);
		chk(v, cnt);
		rd16(8'h02, v);
		chk(v, chg);
		rd16(8'h08, v);
		chk(v, 16'h0800);
		rd16(8'h06, v);
		chk(v, 16'h1FFF);
		repeat (100) @(posedge clk);
		rd16(8'h04, v);
		chk(v, cnt);
		$display("t_frame done");
	endtask : t_frame

	// Light discharge: relax ticks on every second voltage result
	task t_relax;
		cur_val = 14'h3FFF;
		wr(8'h00, 8'h10);
		repeat (150) @(posedge tb_clk);
		rd(8'h10, v);
		chk(v, 16'h0000);
		repeat (150) @(posedge tb_clk);
		rd(8'h10, v);
		chk(v, 16'h0001);
		cur_val = 14'h1FFF;
		repeat (80) @(posedge tb_clk);
		rd(8'h10, v);
		chk(v, 16'h0000);
		wr(8'h00, 8'h00);
		$display("t_relax done");
	endtask : t_relax

	task al(input logic [7:0] a, input logic [7:0] d,
		input logic [15:0] ctl, input logic oe);
		wr(a, d);
		repeat (8) @(posedge clk);
		rd(8'h01, v);
		chk(v, ctl);
		chk({15'h0000, pin_oe}, {15'h0000, oe});
	endtask : al

	task t_alarm;
		wr(8'h00, 8'h08);
		al(8'h0E, 8'h90, 16'h0040, 1'b1);
		al(8'h01, 8'h01, 16'h0001, 1'b0);
		al(8'h0E, 8'h00, 16'h0001, 1'b0);
		al(8'h0E, 8'h90, 16'h0040, 1'b1);
		al(8'h0E, 8'h00, 16'h0040, 1'b1);
		al(8'h01, 8'h01, 16'h0001, 1'b0);
		al(8'h0D, 8'h7F, 16'h0020, 1'b1);
		al(8'h01, 8'h00, 16'h0000, 1'b1);
		$display("t_alarm done");
	endtask : t_alarm

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_reset;
		t_regs;
		t_frame(8'h10, 224, 16'h0007, 16'h1241);
		t_frame(8'h14, 128, 16'h000B, 16'h124F);
		t_relax;
		t_alarm;
		tally_and_finish;
	end
endmodule : battery_gauge_sequencer_test

// ==== tb/bgs_far_model.sv ====
// Model of the converters and the alarm wire seen by the gauge sequencer.
// Assumes results are sampled on the time-base clock at the last slot cycle.
`timescale 1ns/1ns

module bgs_far_model (
	input wire logic tb_clk,
	input wire logic volt_go,
	input wire logic cur_go,
	input wire logic [bgs_pkg::BGS_CUR_W-1:0] cur_val,
	input wire logic [bgs_pkg::BGS_VOLT_W-1:0] volt_val,
	input wire logic pin_oe,
	input wire logic pin_out,
	output logic [bgs_pkg::BGS_CUR_W-1:0] cur_code,
	output logic [bgs_pkg::BGS_VOLT_W-1:0] volt_code,
	output logic pin
);
	// -----------------------------------------------------------------
	// Converter outputs
	// -----------------------------------------------------------------
	// Outside a slot the codes toggle, so a stray sample cannot match
	always_ff @(posedge tb_clk) begin
		cur_code <= cur_go ? cur_val : ~cur_code;
		volt_code <= volt_go ? volt_val : ~volt_code;
	end

	// Open drain with pull-up: a released wire reads high
	assign pin = pin_oe ? pin_out : 1'b1;
endmodule : bgs_far_model
